/* File: usgw_sleep_gate.sv */
`timescale 1ns/10ps
`include "usgw_regs.svh"
module usgw_sleep_gate
  import usgw_pkg::*;
#(
  parameter int DEB_CYC = `USGW_VBUS_DEB_CYC,
  parameter int RWAKE_CYC = `USGW_RWAKE_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic bus_power_sense,
  input wire logic link_suspended,
  input wire logic link_resume,
  input wire logic sleep_request,
  input wire logic wake_event,
  input wire logic startup_ready_message,
  input wire logic ss_capable,
  input wire logic fw_download,
  input wire logic wakeup_port_selection,
  input wire logic wakeup_pin_assignment,
  input wire logic enum_done,
  output logic sleep_enable,
  output logic remote_wakeup_req,
  output logic ring_indicator_line,
  output logic keep_data_conn,
  output logic drop_data_conn,
  output logic reenumerate,
  output logic ss_mode_en,
  output logic hs_mode_en,
  output logic fs_mode_en,
  output logic attached
);

  typedef enum logic [1:0] {
    USGW_AWAKE,
    USGW_ASLEEP
  } usgw_pwr_t;

  usgw_pwr_t pwr;
  usgw_speed_t speed;
  logic [15:0] deb_cnt;
  logic [15:0] rwake_cnt;
  logic attached_prev;
  logic event_pending;
  logic fw_prev;
  logic sleep_ok;
  logic wake_cond;

  ////////////////////////////////////////////////////////////////////////
  // Attachment detection, filtered against bounce on connector insertion
  // attach and detach detect
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      deb_cnt <= 16'h0000;
      attached <= 1'b0;
    end else if (bus_power_sense == attached) begin
      deb_cnt <= 16'h0000;
    end else if (deb_cnt >= 16'(DEB_CYC - 1)) begin
      deb_cnt <= 16'h0000;
      attached <= bus_power_sense;
    end else begin
      deb_cnt <= deb_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      attached_prev <= 1'b0;
      fw_prev <= 1'b0;
    end else begin
      attached_prev <= attached;
      fw_prev <= fw_download;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep permission: an active link always vetoes sleep
  // sleep gating
  assign sleep_ok = (link_suspended || !attached) && !startup_ready_message;
  assign wake_cond = (attached && link_resume) || (attached && !attached_prev) || !sleep_ok;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pwr <= USGW_AWAKE;
    end else begin
      case (pwr)
        USGW_AWAKE: begin
          if (sleep_request && sleep_ok) begin
            pwr <= USGW_ASLEEP;
          end
        end
        USGW_ASLEEP: begin
          if (wake_cond) begin
            pwr <= USGW_AWAKE;
          end
        end
        default: pwr <= USGW_AWAKE;
      endcase
    end
  end

  // Combinational so a link coming alive drops permission at once
  assign sleep_enable = (pwr == USGW_ASLEEP) && sleep_ok;

  ////////////////////////////////////////////////////////////////////////
  // Remote wakeup request while the link is suspended
  // suspend remote wakeup
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rwake_cnt <= 16'h0000;
      remote_wakeup_req <= 1'b0;
    end else if (rwake_cnt != 16'h0000) begin
      rwake_cnt <= rwake_cnt - 16'h0001;
      remote_wakeup_req <= (rwake_cnt != 16'h0001) && link_suspended;
    end else if (wake_event && attached && link_suspended) begin
      rwake_cnt <= 16'(RWAKE_CYC);
      remote_wakeup_req <= 1'b1;
    end else begin
      remote_wakeup_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Detached wakeup line; the event stays flagged until enumeration ends,
  // so nothing is lost while the host reattaches. Set wins over clear.
  // detached wakeup line
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      event_pending <= 1'b0;
    end else if (wake_event && !attached) begin
      event_pending <= 1'b1;
    end else if (attached && enum_done) begin
      event_pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ring_indicator_line <= 1'b0;
    end else begin
      // A fresh event drives the line on the next edge, without waiting a cycle for the flag
      ring_indicator_line <= (event_pending || wake_event) && !attached && wakeup_pin_assignment;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data connection survival across detach
  // keep data connections
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      keep_data_conn <= 1'b0;
      drop_data_conn <= 1'b0;
    end else begin
      keep_data_conn <= wakeup_port_selection && wakeup_pin_assignment;
      drop_data_conn <= !attached && attached_prev && !(wakeup_port_selection && wakeup_pin_assignment);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Speed mode selection; one encoded speed state so HS and SS can never coexist
  // speed exclusivity
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      speed <= USGW_SPD_NONE;
    end else if (!attached) begin
      speed <= USGW_SPD_NONE;
    end else if (fw_download) begin
      speed <= USGW_SPD_HS;
    end else if (speed == USGW_SPD_NONE) begin
      speed <= ss_capable ? USGW_SPD_SS : USGW_SPD_HS;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ss_mode_en <= 1'b0;
      hs_mode_en <= 1'b0;
      fs_mode_en <= 1'b0;
    end else begin
      ss_mode_en <= (speed == USGW_SPD_SS);
      hs_mode_en <= (speed == USGW_SPD_HS);
      fs_mode_en <= (speed == USGW_SPD_HS) || (speed == USGW_SPD_FS);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reenumerate <= 1'b0;
    end else begin
      reenumerate <= fw_download && !fw_prev && attached;
    end
  end

endmodule // usgw_sleep_gate

/* File: usgw_regs.svh */
`ifndef USGW_REGS_SVH
`define USGW_REGS_SVH
// Clock rate in kHz
`define USGW_CLK_KHZ 25000
// Bus power sense debounce time in microseconds
`define USGW_VBUS_DEB_US 10
`define USGW_VBUS_DEB_CYC ((`USGW_VBUS_DEB_US * `USGW_CLK_KHZ + 999) / 1000)
// Remote wakeup request pulse length in microseconds
`define USGW_RWAKE_US 4
`define USGW_RWAKE_CYC ((`USGW_RWAKE_US * `USGW_CLK_KHZ + 999) / 1000)
// Speed mode codes
`define USGW_SPEED_W 2
`endif

/* File: usgw_pkg.sv */
package usgw_pkg;
  typedef enum logic [1:0] {
    USGW_SPD_NONE,
    USGW_SPD_FS,
    USGW_SPD_HS,
    USGW_SPD_SS
  } usgw_speed_t;
endpackage

/* File: usgw_chk.sv */
`timescale 1ns/10ps
// Watches gating, wakeup and speed outputs of the sleep gate
module usgw_chk #(
  parameter int DEB_CYC = 2,
  parameter int RWAKE_CYC = 3
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic bus_power_sense,
  input wire logic link_suspended,
  input wire logic wake_event,
  input wire logic startup_ready_message,
  input wire logic fw_download,
  input wire logic wakeup_pin_assignment,
  input wire logic sleep_enable,
  input wire logic remote_wakeup_req,
  input wire logic ring_indicator_line,
  input wire logic reenumerate,
  input wire logic ss_mode_en,
  input wire logic hs_mode_en,
  input wire logic attached
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  property p_spd; !(ss_mode_en && hs_mode_en); endproperty
  a_spd: assert property (p_spd) else $error("two speed modes");
  property p_slp; sleep_enable |-> link_suspended || !attached; endproperty
  a_slp: assert property (p_slp) else $error("sleep on live link");
  property p_msg; startup_ready_message |-> !sleep_enable; endproperty
  a_msg: assert property (p_msg) else $error("sleep with unread message");
  property p_rwk; wake_event && attached && link_suspended && !remote_wakeup_req |=> remote_wakeup_req; endproperty
  a_rwk: assert property (p_rwk) else $error("no remote wakeup");
  property p_rng; wake_event && !attached && wakeup_pin_assignment |=> ring_indicator_line; endproperty
  a_rng: assert property (p_rng) else $error("no wakeup line");
  property p_enu; $rose(fw_download) && attached |=> reenumerate; endproperty
  a_enu: assert property (p_enu) else $error("no reenumeration");
  property p_fwh; (attached && fw_download) [*3] |-> hs_mode_en && !ss_mode_en; endproperty
  a_fwh: assert property (p_fwh) else $error("download not high speed");
  // Debounce: attach only after stable power sense
  property p_att; $rose(attached) |-> $past(bus_power_sense) && $past(bus_power_sense, 2); endproperty
  a_att: assert property (p_att) else $error("attach not debounced");
  c_slp: cover property ($rose(sleep_enable));
  c_rwk: cover property ($rose(remote_wakeup_req));
  c_rng: cover property ($rose(ring_indicator_line));
endmodule // usgw_chk

/* File: usgw_host.sv */
`timescale 1ns/10ps
// Host controller: power, suspend, resume on request, enumeration
module usgw_host (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic attach,
  input wire logic suspend,
  input wire logic remote_wakeup_req,
  input wire logic ring_indicator_line,
  output logic bus_power_sense,
  output logic link_suspended,
  output logic link_resume,
  output logic enum_done
);
  // power held in suspend, reattach on wakeup line
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {bus_power_sense, link_suspended, link_resume, enum_done} <= 4'h0;
    end else begin
      bus_power_sense <= attach | ring_indicator_line;
      link_suspended <= suspend & bus_power_sense & ~link_resume;
      link_resume <= link_suspended & remote_wakeup_req;
      enum_done <= bus_power_sense & ~link_suspended;
    end
  end
endmodule // usgw_host

/* File: tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_top;
  logic mclk = 0, rst_b = 0, attach = 0, suspend = 0, sleep_request = 0, wake_event = 0, startup_ready_message = 0;
  logic ss_capable = 0, fw_download = 0, wakeup_port_selection = 0, wakeup_pin_assignment = 0;
  logic bus_power_sense, link_suspended, link_resume, enum_done, sleep_enable, remote_wakeup_req;
  logic ring_indicator_line, keep_data_conn, drop_data_conn, reenumerate, ss_mode_en, hs_mode_en, fs_mode_en, attached;
  int errors = 0, n_tests = 0;
  // Short counts keep the run brief
  usgw_sleep_gate #(.DEB_CYC(2), .RWAKE_CYC(3)) usgw_sleep_gate_i (.*);
  usgw_host usgw_host_i (.*);
  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic pulse_event;
    @(posedge mclk);
    wake_event <= 1'b1;
    @(posedge mclk);
    wake_event <= 1'b0;
    cyc(1);
  endtask
  task automatic t_suspend;
    @(posedge mclk);
    attach <= 1'b1;
    ss_capable <= 1'b1;
    sleep_request <= 1'b1;
    cyc(8);
    `CHK(ss_mode_en, 1'b1)
    `CHK(sleep_enable, 1'b0)
    @(posedge mclk);
    suspend <= 1'b1;
    startup_ready_message <= 1'b1;
    cyc(4);
    `CHK(sleep_enable, 1'b0)
    @(posedge mclk);
    startup_ready_message <= 1'b0;
    cyc(2);
    `CHK(sleep_enable, 1'b1)
    pulse_event();
    `CHK(remote_wakeup_req, 1'b1)
    cyc(2);
    `CHK(sleep_enable, 1'b0)
    @(posedge mclk);
    suspend <= 1'b0;
    $display("suspend test done");
  endtask
  task automatic t_fw;
    @(posedge mclk);
    fw_download <= 1'b1;
    cyc(2);
    `CHK(reenumerate, 1'b1)
    cyc(3);
    `CHK({hs_mode_en, ss_mode_en}, 2'h2)
    `CHK(fs_mode_en, 1'b1)
    @(posedge mclk);
    fw_download <= 1'b0;
    $display("download test done");
  endtask
  task automatic t_detach;
    @(posedge mclk);
    wakeup_port_selection <= 1'b1;
    wakeup_pin_assignment <= 1'b1;
    attach <= 1'b0;
    cyc(8);
    `CHK({attached, sleep_enable, keep_data_conn}, 3'h3)
    `CHK(drop_data_conn, 1'b0)
    pulse_event();
    `CHK(ring_indicator_line, 1'b1)
    @(posedge mclk);
    attach <= 1'b1;
    cyc(10);
    `CHK({ring_indicator_line, sleep_enable}, 2'h0)
    $display("detach test done");
  endtask
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence after a 20 cycle reset
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_suspend();
    t_fw();
    t_detach();
    conclude();
  end
  // Watchdog: the tests need under 200 cycles
  initial begin
    repeat (2000) @(posedge mclk);
    errors++;
    conclude();
  end
endmodule // tb_top
bind usgw_sleep_gate usgw_chk #(.DEB_CYC(DEB_CYC), .RWAKE_CYC(RWAKE_CYC)) usgw_chk_i (.*);
